// file: rtl/board_watchdog_power_control.sv
// Purpose: board watchdog with timeout action and simple power button control
// Assumes: 100 MHz ref_clk, async active-high rst, button pin asynchronous
// Notes:   timeout flags live in the board logic and counter, sticky by design

`timescale 1ns/1ps

module board_watchdog_power_control #(
  parameter int       CYC_PER_SEC = wdt_pkg::CLK_HZ,
  parameter logic [7:0] POST_COUNT  = 8'h3B // self-test watchdog count
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            busRst,
  // register port
  input  wire wdt_pkg::bus_req_s busReq,
  output logic [7:0]           rdData,
  // self-test phase
  input  wire logic            postActive,
  // power button and sleep request
  input  wire logic            pwrButton,
  input  wire logic            sleepReq,
  // board outputs
  output logic                 powerEn,
  output logic                 coldReset,
  output logic                 wdtPinOut,
  output logic                 wdtPinOe,
  output logic                 irq
);

  localparam int OFF_CYC = wdt_pkg::OFF_TIME_S * CYC_PER_SEC;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0]  action_reg;    // action field
  logic        pldFlag_reg;   // board logic timeout flag
  logic [7:0]  pinCfg_reg;    // output pin configuration
  logic [7:0]  scale_reg;     // timescale
  logic [7:0]  count_reg;     // timeout count
  logic        cFlag_reg;     // counter timeout flag
  logic [1:0]  irqStat_reg;   // sticky events
  logic [1:0]  irqMask_reg;   // event mask
  logic [1:0]  btnSync_reg;   // button synchroniser
  logic        btnPrev_reg;   // button edge history
  logic [31:0] offCnt_reg;    // power-off timer
  logic        postArm_reg;   // self-test arming done
  logic        pinAct_reg;    // watchdog pin asserted
  wdt_pkg::power_e pwr_reg;   // power state

  logic wrAct, wrPin, wrScale, wrCount, wrCStat, wrIrqS, wrIrqM;
  logic secTick, minTick, unitTick, expire, reload, btnPress, pwrEvent;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign wrAct   = busReq.wr && busReq.addr == wdt_pkg::ADDR_ACTION;
  assign wrPin   = busReq.wr && busReq.addr == wdt_pkg::ADDR_PINCFG;
  assign wrScale = busReq.wr && busReq.addr == wdt_pkg::ADDR_SCALE;
  assign wrCount = busReq.wr && busReq.addr == wdt_pkg::ADDR_COUNT;
  assign wrCStat = busReq.wr && busReq.addr == wdt_pkg::ADDR_CSTAT;
  assign wrIrqS  = busReq.wr && busReq.addr == wdt_pkg::ADDR_IRQSTAT;
  assign wrIrqM  = busReq.wr && busReq.addr == wdt_pkg::ADDR_IRQMASK;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      action_reg  <= wdt_pkg::RST_ACTION[wdt_pkg::ACT_LO +: 2];
      pinCfg_reg  <= wdt_pkg::RST_PINCFG;
      scale_reg   <= wdt_pkg::RST_SCALE;
      irqMask_reg <= 2'b00;
    end else begin
      if (wrAct) begin
        action_reg <= busReq.wdata[wdt_pkg::ACT_LO +: 2];
      end
      if (wrPin) begin
        pinCfg_reg <= busReq.wdata;
      end
      if (wrScale) begin
        scale_reg <= busReq.wdata;
      end
      if (wrIrqM) begin
        irqMask_reg <= busReq.wdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // timeout count; self-test arms it once after reset
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg   <= wdt_pkg::RST_COUNT;
      postArm_reg <= 1'b0;
    end else if (wrCount) begin
      count_reg   <= busReq.wdata;
      postArm_reg <= 1'b1;
    end else if (!postArm_reg && postActive) begin
      count_reg   <= POST_COUNT;
      postArm_reg <= 1'b1;
    end
  end

  // a software write or the self-test arming restarts the interval
  assign reload = wrCount || (!postArm_reg && postActive);

  // ----------------------------------------------------------------
  // timebase and countdown
  // ----------------------------------------------------------------
  wdt_tick_gen #(
    .CYC_PER_SEC (CYC_PER_SEC),
    .SEC_PER_MIN (wdt_pkg::SEC_PER_MIN)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst     (rst),
    .restart (reload),
    .secTick (secTick),
    .minTick (minTick)
  );

  assign unitTick = scale_reg[wdt_pkg::SCALE_SEC] ? secTick : minTick;

  wdt_countdown u_count (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .reload   (reload),
    .countVal (reload && !wrCount ? POST_COUNT : busReq.wdata),
    .unitTick (unitTick),
    .expire   (expire)
  );

  // ----------------------------------------------------------------
  // counter flag: only power-on reset or a write of one clears it;
  // the bus reset is deliberately not wired in here
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cFlag_reg <= 1'b0;
    end else if (expire) begin
      cFlag_reg <= 1'b1; // set wins over clear
    end else if (wrCStat && busReq.wdata[wdt_pkg::CSTAT_FLAG]) begin
      cFlag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // watchdog output pin: asserted for one cycle on expiry when the pin function is selected
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinAct_reg <= 1'b0;
    end else if (expire && pinCfg_reg[wdt_pkg::PIN_FUNC]) begin
      pinAct_reg <= 1'b1;
    end else if (pinAct_reg) begin
      pinAct_reg <= 1'b0; // one-cycle request to board logic
    end
  end

  assign wdtPinOut = pinAct_reg ^ pinCfg_reg[wdt_pkg::PIN_INV];
  // open drain lets go of the pin whenever it would be high
  assign wdtPinOe  = pinCfg_reg[wdt_pkg::PIN_FUNC]
                   && !(pinCfg_reg[wdt_pkg::PIN_ODRN] && wdtPinOut);

  // ----------------------------------------------------------------
  // board logic timeout flag, kept over the action it triggers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pldFlag_reg <= 1'b0;
    end else if (pinAct_reg) begin
      pldFlag_reg <= 1'b1;
    end else if (wrAct && busReq.wdata[wdt_pkg::ACT_FLAG]) begin
      pldFlag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power button synchroniser and edge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      btnSync_reg <= 2'b00;
      btnPrev_reg <= 1'b0;
    end else begin
      btnSync_reg <= {btnSync_reg[0], pwrButton};
      btnPrev_reg <= btnSync_reg[1];
    end
  end

  // button has no register and raises no event: hardware only
  assign btnPress = btnSync_reg[1] && !btnPrev_reg;

  // ----------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pwr_reg    <= wdt_pkg::PWR_ON;
      offCnt_reg <= 32'h0000_0000;
    end else begin
      case (pwr_reg)
        wdt_pkg::PWR_ON: begin
          if (btnPress) begin
            pwr_reg <= wdt_pkg::PWR_OFF;
          end else if (pinAct_reg) begin
            case (wdt_pkg::action_e'(action_reg))
              wdt_pkg::ACT_RESET: pwr_reg <= wdt_pkg::PWR_RESET;
              wdt_pkg::ACT_CYCLE: begin
                pwr_reg    <= wdt_pkg::PWR_CYCOFF;
                offCnt_reg <= 32'h0000_0000;
              end
              wdt_pkg::ACT_OFF:   pwr_reg <= wdt_pkg::PWR_OFF;
              default:            pwr_reg <= wdt_pkg::PWR_ON;
            endcase
          end else if (sleepReq) begin
            pwr_reg <= wdt_pkg::PWR_SLEEP;
          end
        end
        wdt_pkg::PWR_RESET: begin
          pwr_reg <= wdt_pkg::PWR_ON; // one-cycle cold reset pulse
        end
        wdt_pkg::PWR_CYCOFF: begin
          if (offCnt_reg == 32'(OFF_CYC - 1)) begin
            pwr_reg <= wdt_pkg::PWR_ON;
          end else begin
            offCnt_reg <= offCnt_reg + 32'h0000_0001;
          end
        end
        wdt_pkg::PWR_OFF, wdt_pkg::PWR_SLEEP: begin
          if (btnPress) begin
            pwr_reg <= wdt_pkg::PWR_ON;
          end
        end
        default: pwr_reg <= wdt_pkg::PWR_ON;
      endcase
    end
  end

  assign powerEn   = (pwr_reg == wdt_pkg::PWR_ON) || (pwr_reg == wdt_pkg::PWR_RESET);
  assign coldReset = (pwr_reg == wdt_pkg::PWR_RESET);
  assign pwrEvent  = pinAct_reg && action_reg != 2'b00;

  // ----------------------------------------------------------------
  // interrupt status, write one to clear, set wins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqStat_reg <= 2'b00;
    end else begin
      irqStat_reg <= (irqStat_reg & ~(wrIrqS ? busReq.wdata[1:0] : 2'b00))
                   | {pwrEvent, expire};
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  // ----------------------------------------------------------------
  // read data, one cycle after the strobe; busRst resets only the port
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (busRst || !busReq.rd) begin
      rdData <= 8'h00;
    end else begin
      case (busReq.addr)
        wdt_pkg::ADDR_ACTION:  rdData <= {pldFlag_reg, 1'b0, action_reg, 4'h0};
        wdt_pkg::ADDR_PINCFG:  rdData <= pinCfg_reg;
        wdt_pkg::ADDR_SCALE:   rdData <= scale_reg;
        wdt_pkg::ADDR_COUNT:   rdData <= count_reg;
        wdt_pkg::ADDR_CSTAT:   rdData <= {7'h00, cFlag_reg};
        wdt_pkg::ADDR_IRQSTAT: rdData <= {6'h00, irqStat_reg};
        wdt_pkg::ADDR_IRQMASK: rdData <= {6'h00, irqMask_reg};
        default:               rdData <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_flag_set;
    @(posedge ref_clk) disable iff (rst) expire |=> cFlag_reg;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("counter flag not set");

  // pin request first, board logic flag one cycle later
  sequence s_pin_then_flag;
    pinAct_reg ##1 pldFlag_reg;
  endsequence

  property p_pin_follow;
    @(posedge ref_clk) disable iff (rst)
      expire && pinCfg_reg[wdt_pkg::PIN_FUNC] |=> s_pin_then_flag;
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin or board flag late");

  property p_btn_off;
    @(posedge ref_clk) disable iff (rst)
      pwr_reg == wdt_pkg::PWR_ON && btnPress |=> !powerEn;
  endproperty
  a_btn_off: assert property (p_btn_off) else $error("button did not power off");

  property p_cycle_off;
    @(posedge ref_clk) disable iff (rst)
      pwr_reg == wdt_pkg::PWR_ON && $past(pwr_reg) == wdt_pkg::PWR_CYCOFF
      |-> offCnt_reg == 32'(OFF_CYC - 1);
  endproperty
  a_cycle_off: assert property (p_cycle_off) else $error("off time wrong");

  property p_flag_sticky;
    @(posedge ref_clk) disable iff (rst)
      cFlag_reg && !(wrCStat && busReq.wdata[0]) |=> cFlag_reg;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_zero_off;
    @(posedge ref_clk) disable iff (rst)
      wrCount && busReq.wdata == 8'h00 |=> !expire [*8];
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("expired while disabled");

  property p_wake;
    @(posedge ref_clk) disable iff (rst)
      pwr_reg == wdt_pkg::PWR_SLEEP && btnPress |=> powerEn;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_reset_pulse;
    @(posedge ref_clk) disable iff (rst)
      coldReset |=> !coldReset && powerEn;
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse wrong");

endmodule

// file: rtl/wdt_countdown.sv
// Purpose: watchdog down counter in seconds or minutes
// Assumes: reload pulse on every write of the timeout count
// Notes:   interval is count plus one units; zero count disables

`timescale 1ns/1ps

module wdt_countdown (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // control
  input  wire logic       reload,
  input  wire logic [7:0] countVal,
  input  wire logic       unitTick,
  // result
  output logic            expire
);

  logic [8:0] remain_reg; // units left before expiry
  logic       armed_reg;  // counting in progress

  // ----------------------------------------------------------------
  // countdown; a reload restarts the full interval
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      remain_reg <= 9'h000;
      armed_reg  <= 1'b0;
    end else if (reload) begin
      remain_reg <= {1'b0, countVal} + 9'h001;
      armed_reg  <= (countVal != 8'h00);
    end else if (armed_reg && unitTick) begin
      remain_reg <= remain_reg - 9'h001;
      if (remain_reg == 9'h001) begin
        armed_reg <= 1'b0; // one shot until fed again
      end
    end
  end

  assign expire = armed_reg && unitTick && (remain_reg == 9'h001);

endmodule

// file: rtl/wdt_tick_gen.sv
// Purpose: one-cycle ticks once per second and once per minute
// Assumes: single clock domain, counts shortened by parameter in simulation
// Notes:   restartable so a feed aligns the first tick

`timescale 1ns/1ps

module wdt_tick_gen #(
  parameter int CYC_PER_SEC = wdt_pkg::CLK_HZ,
  parameter int SEC_PER_MIN = wdt_pkg::SEC_PER_MIN
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control
  input  wire logic restart,
  // ticks
  output logic      secTick,
  output logic      minTick
);

  logic [31:0] cycCnt_reg; // cycles within the current second
  logic [7:0]  secCnt_reg; // seconds within the current minute

  // ----------------------------------------------------------------
  // second prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cycCnt_reg <= 32'h0000_0000;
    end else if (restart || cycCnt_reg == 32'(CYC_PER_SEC - 1)) begin
      cycCnt_reg <= 32'h0000_0000;
    end else begin
      cycCnt_reg <= cycCnt_reg + 32'h0000_0001;
    end
  end

  assign secTick = !restart && (cycCnt_reg == 32'(CYC_PER_SEC - 1));

  // ----------------------------------------------------------------
  // minute prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      secCnt_reg <= 8'h00;
    end else if (restart) begin
      secCnt_reg <= 8'h00;
    end else if (secTick) begin
      secCnt_reg <= (secCnt_reg == 8'(SEC_PER_MIN - 1)) ? 8'h00 : secCnt_reg + 8'h01;
    end
  end

  assign minTick = secTick && (secCnt_reg == 8'(SEC_PER_MIN - 1));

endmodule

// file: shared/wdt_pkg.sv
// Purpose: shared constants and types for the board watchdog and power control
// Assumes: 100 MHz ref_clk, plain register port with one-cycle read latency
// Notes:   register addresses are 12-bit byte offsets

package wdt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_ACTION   = 12'h01D3; // action field and latched flag
  localparam logic [11:0] ADDR_PINCFG   = 12'h0C47; // output pin configuration
  localparam logic [11:0] ADDR_SCALE    = 12'h0C65; // timescale
  localparam logic [11:0] ADDR_COUNT    = 12'h0C66; // timeout count
  localparam logic [11:0] ADDR_CSTAT    = 12'h0C68; // counter status
  localparam logic [11:0] ADDR_IRQSTAT  = 12'h0C70; // sticky event status
  localparam logic [11:0] ADDR_IRQMASK  = 12'h0C71; // event mask

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ACTION = 8'h00;
  localparam logic [7:0] RST_PINCFG = 8'h0E;
  localparam logic [7:0] RST_SCALE  = 8'h08;
  localparam logic [7:0] RST_COUNT  = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ACT_LO      = 4;  // action field bits 5:4
  localparam int ACT_FLAG    = 7;  // board logic timeout flag
  localparam int SCALE_SEC   = 7;  // 1 = seconds, 0 = minutes
  localparam int PIN_FUNC    = 3;  // pin function select: watchdog output
  localparam int PIN_INV     = 1;  // 1 = inverted polarity
  localparam int PIN_ODRN    = 7;  // 1 = open drain, 0 = push-pull
  localparam int CSTAT_FLAG  = 0;  // counter timeout flag
  localparam int EV_TIMEOUT  = 0;  // event bit: watchdog expiry
  localparam int EV_POWER    = 1;  // event bit: watchdog power action (button and sleep raise none)

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int OFF_TIME_S    = 3;   // power-cycle off time in seconds
  localparam int SEC_PER_MIN   = 60;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_NONE  = 2'b00,
    ACT_RESET = 2'b01,
    ACT_CYCLE = 2'b10,
    ACT_OFF   = 2'b11
  } action_e;

  typedef enum logic [2:0] {
    PWR_ON     = 3'b000,
    PWR_RESET  = 3'b001,
    PWR_CYCOFF = 3'b010,
    PWR_OFF    = 3'b011,
    PWR_SLEEP  = 3'b100
  } power_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_s;

endpackage

// file: verification/tb_board_watchdog_power_control.sv
// Purpose: self-checking bench for the board watchdog and power control block
// Assumes: seconds shortened to CPS cycles; register reads land one cycle after rd
// Notes:   pin pulses, reset pulses and off time are counted by small monitors

`timescale 1ns/1ps

module tb_board_watchdog_power_control;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int     CPS = 10;        // short second keeps the run small
  logic              ref_clk;         // 100 MHz clock
  logic              rst;             // async reset
  logic              busRst;          // bus reset, flags must survive it
  logic              postActive;      // self-test phase
  logic              pwrButton;       // button level
  logic              sleepReq;        // sleep request
  wdt_pkg::bus_req_s busReq;          // register request
  logic [7:0]        rdData;          // register answer
  logic              powerEn;         // board power
  logic              coldReset;       // reset pulse
  logic              wdtPinOut;       // watchdog pin value
  logic              wdtPinOe;        // watchdog pin drive
  logic              irq;             // event interrupt
  int                badCount;        // mismatches
  int                samplesChecked;  // comparisons
  int                pinSeen;         // pin pulses so far
  int                resetSeen;       // reset pulses so far
  int                offCnt;          // cycles with power removed

  board_watchdog_power_control #(.CYC_PER_SEC(CPS), .POST_COUNT(8'h01)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .busRst(busRst), .busReq(busReq), .rdData(rdData),
    .postActive(postActive), .pwrButton(pwrButton), .sleepReq(sleepReq),
    .powerEn(powerEn), .coldReset(coldReset), .wdtPinOut(wdtPinOut),
    .wdtPinOe(wdtPinOe), .irq(irq));

  // ----------------------------------------------------------------
  // clock and monitors
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // monitors count one-cycle pulses so no task can miss them
  always @(posedge ref_clk) begin
    if (wdtPinOe === 1'b1 && wdtPinOut === 1'b0) pinSeen++;
    if (coldReset === 1'b1) resetSeen++;
    if (powerEn === 1'b0) offCnt++;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic testDone;
    $display("checks=%0d mismatches=%0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      badCount++;
    end
  endtask

  // boolean range test, reported as a byte compare
  task automatic inRange(input int n, input int lo, input int hi);
    check({7'h00, (n >= lo && n <= hi)}, 8'h01);
  endtask

  task automatic regWr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk) busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) busReq.wr <= 1'b0;
  endtask

  // data stands only in the cycle after the strobe
  task automatic regRd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk) busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) busReq.rd <= 1'b0;
    @(negedge ref_clk) check(rdData, exp);
  endtask

  // bounded wait for the next pin pulse; n returns elapsed cycles
  task automatic waitPin(input int lim, output int n);
    int base;
    base = pinSeen;
    n = 0;
    while (pinSeen == base) begin
      @(negedge ref_clk) n++;
      if (n > lim) begin
        check(8'h00, 8'h01);
        testDone();
      end
    end
  endtask

  // press long enough to clear the two-flop synchroniser
  task automatic press;
    @(posedge ref_clk) pwrButton <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pwrButton <= 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic tResetValues;
    regRd(wdt_pkg::ADDR_ACTION, 8'h00);
    regRd(wdt_pkg::ADDR_PINCFG, 8'h0E);
    regRd(wdt_pkg::ADDR_SCALE, 8'h08);
    regRd(wdt_pkg::ADDR_COUNT, 8'h00);
    regRd(wdt_pkg::ADDR_CSTAT, 8'h00);
    regWr(12'h0C67, 8'hFF);
    regRd(12'h0C67, 8'h00);
    check({6'h00, wdtPinOe, wdtPinOut}, 8'h03);
    regWr(wdt_pkg::ADDR_PINCFG, 8'h8E);
    @(negedge ref_clk) check({7'h00, wdtPinOe}, 8'h00);
    regWr(wdt_pkg::ADDR_PINCFG, 8'h0E);
  endtask

  // feeds hold off expiry; zero count stops it
  task automatic tFeedDisable;
    int n;
    int base;
    regWr(wdt_pkg::ADDR_SCALE, 8'h80);
    base = pinSeen;
    regWr(wdt_pkg::ADDR_COUNT, 8'h02);
    regRd(wdt_pkg::ADDR_CSTAT, 8'h00);
    repeat (3) begin
      repeat (20) @(posedge ref_clk);
      regWr(wdt_pkg::ADDR_COUNT, 8'h02);
    end
    check(8'(pinSeen - base), 8'h00);
    waitPin(60, n);
    inRange(n, 28, 33);
    regWr(wdt_pkg::ADDR_COUNT, 8'h01);
    regWr(wdt_pkg::ADDR_COUNT, 8'h00);
    base = pinSeen;
    repeat (60) @(posedge ref_clk);
    check(8'(pinSeen - base), 8'h00);
    regRd(wdt_pkg::ADDR_CSTAT, 8'h01);
  endtask

  // masked and unmasked interrupt, bus reset, write-one clears
  task automatic tFlags;
    regWr(wdt_pkg::ADDR_IRQMASK, 8'h00);
    repeat (2) @(negedge ref_clk);
    check({7'h00, irq}, 8'h00);
    regWr(wdt_pkg::ADDR_IRQMASK, 8'h01);
    repeat (2) @(negedge ref_clk);
    check({7'h00, irq}, 8'h01);
    @(posedge ref_clk) busRst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    busRst <= 1'b0;
    regRd(wdt_pkg::ADDR_CSTAT, 8'h01);
    regWr(wdt_pkg::ADDR_IRQSTAT, 8'hFF);
    regWr(wdt_pkg::ADDR_CSTAT, 8'h01);
    regWr(wdt_pkg::ADDR_ACTION, 8'h80);
    repeat (2) @(negedge ref_clk);
    check({7'h00, irq}, 8'h00);
    regRd(wdt_pkg::ADDR_CSTAT, 8'h00);
    regRd(wdt_pkg::ADDR_ACTION, 8'h00);
  endtask

  // one expiry per action code, flags checked afterwards
  task automatic tAction(input logic [1:0] act);
    int n;
    int rs;
    regWr(wdt_pkg::ADDR_ACTION, {2'b00, act, 4'h0});
    rs = resetSeen;
    offCnt = 0;
    regWr(wdt_pkg::ADDR_COUNT, 8'h01);
    waitPin(40, n);
    inRange(n, 18, 23);
    regWr(wdt_pkg::ADDR_COUNT, 8'h00);
    repeat (40) @(negedge ref_clk);
    check({7'h00, powerEn}, {7'h00, act != wdt_pkg::ACT_OFF});
    check(8'(resetSeen - rs), {7'h00, act == wdt_pkg::ACT_RESET});
    if (act == wdt_pkg::ACT_CYCLE) inRange(offCnt, 3 * CPS - 2, 3 * CPS + 2);
    if (act == wdt_pkg::ACT_NONE) check(offCnt[7:0], 8'h00);
    regRd(wdt_pkg::ADDR_ACTION, {2'b10, act, 4'h0});
    regRd(wdt_pkg::ADDR_CSTAT, 8'h01);
    if (act == wdt_pkg::ACT_OFF) begin
      press();
      check({7'h00, powerEn}, 8'h01);
    end
    regWr(wdt_pkg::ADDR_ACTION, {2'b10, act, 4'h0});
    regWr(wdt_pkg::ADDR_CSTAT, 8'h01);
    regWr(wdt_pkg::ADDR_IRQSTAT, 8'hFF);
    regRd(wdt_pkg::ADDR_ACTION, {2'b00, act, 4'h0});
  endtask

  // button: on to off, off to on, sleep wake, no events raised
  task automatic tButton;
    regWr(wdt_pkg::ADDR_ACTION, 8'h00);
    regWr(wdt_pkg::ADDR_IRQMASK, 8'hFF);
    press();
    check({7'h00, powerEn}, 8'h00);
    press();
    check({7'h00, powerEn}, 8'h01);
    @(posedge ref_clk) sleepReq <= 1'b1;
    @(posedge ref_clk) sleepReq <= 1'b0;
    repeat (3) @(negedge ref_clk);
    check({7'h00, powerEn}, 8'h00);
    press();
    check({7'h00, powerEn}, 8'h01);
    check({7'h00, irq}, 8'h00);
    regRd(wdt_pkg::ADDR_IRQSTAT, 8'h00);
  endtask

  // fresh reset, then self-test arms the counter on its own, in minutes
  task automatic tPost;
    int n;
    @(posedge ref_clk) rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    regRd(wdt_pkg::ADDR_SCALE, 8'h08);
    @(posedge ref_clk) postActive <= 1'b1;
    waitPin(1300, n);
    inRange(n, 2 * 60 * CPS - 3, 2 * 60 * CPS + 3);
    regRd(wdt_pkg::ADDR_CSTAT, 8'h01);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    busRst = 1'b0;
    postActive = 1'b0;
    pwrButton = 1'b0;
    sleepReq = 1'b0;
    busReq = '0;
    badCount = 0;
    samplesChecked = 0;
    pinSeen = 0;
    resetSeen = 0;
    offCnt = 0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    tResetValues();
    tFeedDisable();
    tFlags();
    for (int a = 0; a < 4; a++) tAction(2'(a));
    tButton();
    tPost();
    testDone();
  end
endmodule
